// [osmg_regs.sv]
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`include "osmg_defines.svh"

module osmg_regs (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire osmg_pkg::osmg_byte_t REG_ADDR,
    input wire osmg_pkg::osmg_byte_t REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output osmg_pkg::osmg_byte_t REG_RDATA,
    input wire logic RX_OVERLOAD_LEVEL,
    input wire logic OFFHOOK_MASK,
    input wire osmg_pkg::osmg_byte_t LINE_CURRENT_MA,
    input wire logic CURRENT_LIMIT_SELECT,
    input wire logic OVERLOAD_PROTECT_ENABLE,
    input wire logic OVERLOAD_PROTECT_WR,
    input wire logic ALT_MAP_SELECT,
    input wire osmg_pkg::osmg_sample_t RX_SAMPLE,
    input wire osmg_pkg::osmg_sample_t TX_SAMPLE,
    input wire logic SAMPLE_VALID,
    output osmg_pkg::osmg_sample_t CALL_PROGRESS_MONITOR_OUTPUT,
    output logic MONITOR_VALID,
    output logic SELF_CLEARING_RX_OVERLOAD_FLAG,
    output logic FEED_OVERLOAD_FLAG
);
    import osmg_pkg::*;

    // Cycles per tick of the slow enable; the feed qualifier counts in these ticks.
    localparam int TICK_CYCLES = `OSMG_TICK_CYCLES;

    // Address match shared by both write decodes, so both write selects are spelled one way.
    function automatic logic addr_hit(input osmg_byte_t addr, input osmg_byte_t offset);
        addr_hit = (addr == offset);
    endfunction : addr_hit

    // Gain actually applied to a path: the stored code inside the alternate map, unity outside.
    // Holding the stored code lets software load the gains before it sets the map select.
    function automatic osmg_byte_t eff_gain(input logic alt_map, input osmg_byte_t code);
        if (alt_map) begin
            eff_gain = code;
        end else begin
            eff_gain = `OSMG_GAIN_UNITY;
        end
    endfunction : eff_gain

    // Reset release, synchroniser and tick divider state.
    logic rst_sync1_q;
    logic rst_n_q;
    logic rx_level_sync;
    logic tick_q;
    logic [7:0] tick_cnt_q;

    // Stored gain codes and the codes actually applied to each path.
    osmg_byte_t monitor_rx_gain_code_q;
    osmg_byte_t monitor_tx_gain_code_q;
    osmg_byte_t rx_gain_eff;
    osmg_byte_t tx_gain_eff;

    // Flags and the feed overload detector.
    logic self_clearing_rx_overload_flag_q;
    logic feed_overload_flag_q;
    osmg_feed_state_t feed_state_q;
    osmg_feed_state_t feed_state_d;
    logic [3:0] feed_qual_q;
    logic [3:0] feed_qual_d;
    logic feed_trip_event;
    osmg_byte_t feed_threshold;
    logic feed_over;

    // Register port decode, read path and the monitor mix.
    logic wr_rx_gain;
    logic wr_tx_gain;
    osmg_scaled_t rx_scaled;
    osmg_scaled_t tx_scaled;
    logic scaled_valid_q;
    osmg_sample_t monitor_q;
    logic monitor_valid_q;
    osmg_byte_t rdata_q;
    osmg_byte_t status_view;

    // Reset is applied at once but released through two flops to avoid a ragged release.
    // Every other process in this block resets from rst_n_q, never from the raw pin.
    // The release therefore reaches all flops on the same edge, two edges after the pin rises.
    // A short glitch on the pin still resets everything at once.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_n_q <= rst_sync1_q;
        end
    end

    // The receive level indicator comes from the analog side, so it is synchronised first.
    // Only the level needs this; every other input is produced on MCLK.
    // The two-flop delay adds to the flag latency, so the flag trails the pin by three edges.
    // Its reset comes from the synchronised copy like every flop outside the reset synchroniser.
    osmg_sync u_rx_level_sync (
        .clk(MCLK),
        .rst_n(rst_n_q),
        .async_in(RX_OVERLOAD_LEVEL),
        .sync_out(rx_level_sync)
    );

    // Divider giving a one-cycle tick every microsecond for the feed qualifier.
    // A single enable pulse stands in for a slower clock, so the whole block stays on MCLK.
    // The divider free-runs from reset, so the first tick after an overload may come
    // anywhere from one to 200 cycles later; the qualifier allows for that spread.
    // The compare value is cut to the counter width on purpose; it fits in eight bits.
    always_ff @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tick_cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 8'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= 8'h00;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
            tick_q <= 1'b0;
        end
    end

    // Self-clearing receive overload flag follows the level, gated by the off-hook mask.
    // Billing-tone enable deliberately plays no part here, unlike the sticky variant.
    // The mask is a same-clock level, so it acts one edge after it changes, while the
    // receive level pin acts three edges late because of the synchroniser.
    // Nothing here latches: once the level falls the flag falls with it.
    always_ff @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            self_clearing_rx_overload_flag_q <= 1'b0;
        end else begin
            self_clearing_rx_overload_flag_q <= rx_level_sync & ~OFFHOOK_MASK;
        end
    end

    // Trip level depends on the current-limit select.
    // The comparison is inclusive: a current equal to the threshold counts as overload.
    // A disabled detector sees no overload at all, so it can neither trip nor hold the flag.
    assign feed_threshold = CURRENT_LIMIT_SELECT ? `OSMG_FEED_TRIP_LOW_MA : `OSMG_FEED_TRIP_HIGH_MA;
    assign feed_over = OVERLOAD_PROTECT_ENABLE && (LINE_CURRENT_MA >= feed_threshold);

    // Feed detector state register.
    // Count and state move together, so the count always starts from entry into qualifying.
    always_ff @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            feed_state_q <= OSMG_FEED_IDLE;
            feed_qual_q <= 4'h0;
        end else begin
            feed_state_q <= feed_state_d;
            feed_qual_q <= feed_qual_d;
        end
    end

    // The qualifier rejects single-sample spikes; a persistent excess trips the flag.
    // Dropping out of qualifying restarts the count, so two ticks of unbroken excess are
    // needed; a noisy line therefore trips a little later than a clean one.
    always_comb begin
        feed_state_d = feed_state_q;
        feed_qual_d = feed_qual_q;
        feed_trip_event = 1'b0;
        case (feed_state_q)
            OSMG_FEED_IDLE: begin
                // Waiting for the condition; the count is held at zero here.
                feed_qual_d = 4'h0;
                if (feed_over) begin
                    feed_state_d = OSMG_FEED_QUAL;
                end
            end
            OSMG_FEED_QUAL: begin
                // Counting ticks while the condition holds without a break.
                if (!feed_over) begin
                    feed_state_d = OSMG_FEED_IDLE;
                end else if (tick_q) begin
                    if (feed_qual_q == `OSMG_FEED_QUAL_TICKS - 4'h1) begin
                        feed_state_d = OSMG_FEED_TRIP;
                        feed_trip_event = 1'b1;
                    end else begin
                        feed_qual_d = feed_qual_q + 4'h1;
                    end
                end
            end
            OSMG_FEED_TRIP: begin
                // Keeps asserting while the overload persists so a clear cannot hide it.
                feed_trip_event = feed_over;
                if (!feed_over) begin
                    feed_state_d = OSMG_FEED_IDLE;
                end
            end
            default: begin
                // Unused code: recover to idle rather than hang.
                feed_state_d = OSMG_FEED_IDLE;
            end
        endcase
    end

    // Sticky feed flag; a trip in the same cycle as the clearing write wins.
    // The trade-off: a clear issued while the overload persists is lost, and software
    // must clear again once the line has recovered. That keeps a live fault visible.
    // Software learns of the trip only by reading; there is no interrupt.
    always_ff @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            feed_overload_flag_q <= 1'b0;
        end else if (feed_trip_event) begin
            feed_overload_flag_q <= 1'b1;
        end else if (OVERLOAD_PROTECT_WR) begin
            feed_overload_flag_q <= 1'b0;
        end
    end

    // Write decode; the status register has no write path at all.
    // Writes to unmapped offsets fall through and change nothing.
    // A write and a read never share a cycle, so no priority is needed here.
    assign wr_rx_gain = REG_WR && addr_hit(REG_ADDR, `OSMG_ADDR_MONITOR_RECEIVE_GAIN);
    assign wr_tx_gain = REG_WR && addr_hit(REG_ADDR, `OSMG_ADDR_MONITOR_TRANSMIT_GAIN);

    // Receive monitor gain register.
    // Written whatever the map select, so software may stage a code in advance.
    always_ff @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            monitor_rx_gain_code_q <= `OSMG_RST_MONITOR_RECEIVE_GAIN;
        end else if (wr_rx_gain) begin
            monitor_rx_gain_code_q <= REG_WDATA;
        end
    end

    // Transmit monitor gain register.
    // Same staging rule as the receive code.
    always_ff @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            monitor_tx_gain_code_q <= `OSMG_RST_MONITOR_TRANSMIT_GAIN;
        end else if (wr_tx_gain) begin
            monitor_tx_gain_code_q <= REG_WDATA;
        end
    end

    // Outside the alternate map the codes are held but the monitor runs at unity,
    // so a half-configured map never mutes the speaker by surprise.
    // The select is sampled at multiply time, so a change acts on the next sample.
    assign rx_gain_eff = eff_gain(ALT_MAP_SELECT, monitor_rx_gain_code_q);
    assign tx_gain_eff = eff_gain(ALT_MAP_SELECT, monitor_tx_gain_code_q);

    // Receive path scaler: linear, zero code gives zero output.
    // Its output register adds one cycle; the mix below adds the second.
    osmg_gain_scale u_rx_scale (
        .clk(MCLK),
        .rst_n(rst_n_q),
        .in_valid(SAMPLE_VALID),
        .sample(RX_SAMPLE),
        .gain_code(rx_gain_eff),
        .scaled(rx_scaled)
    );

    // Transmit path scaler, same law as the receive one.
    // Both scalers share one valid, so the two paths stay aligned sample for sample.
    osmg_gain_scale u_tx_scale (
        .clk(MCLK),
        .rst_n(rst_n_q),
        .in_valid(SAMPLE_VALID),
        .sample(TX_SAMPLE),
        .gain_code(tx_gain_eff),
        .scaled(tx_scaled)
    );

    // Sum both paths and clamp; +6 dB on both can exceed full scale, hence saturation.
    // Saturating costs a comparator but avoids a loud wrap on the speaker.
    // Each path is widened before adding so the sum itself cannot wrap.
    // The output holds its last value between samples, which keeps the tone steady.
    always_ff @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            scaled_valid_q <= 1'b0;
            monitor_q <= '0;
            monitor_valid_q <= 1'b0;
        end else begin
            scaled_valid_q <= SAMPLE_VALID;
            monitor_valid_q <= scaled_valid_q;
            if (scaled_valid_q) begin
                monitor_q <= osmg_saturate(20'(rx_scaled) + 20'(tx_scaled));
            end
        end
    end

    // Status view: reserved bits are constant zero.
    // Bit 1 sits between the flags and is reserved like the upper five.
    // The positions come from the shared defines, so every reader agrees on them.
    // Flags are read live; a read never clears either of them.
    always_comb begin
        status_view = 8'h00;
        status_view[`OSMG_BIT_SELF_CLEARING_RX_OVERLOAD] = self_clearing_rx_overload_flag_q;
        status_view[`OSMG_BIT_FEED_OVERLOAD] = feed_overload_flag_q;
    end

    // Read data is registered and stands only in the cycle after the strobe.
    // Driving zero outside the answer cycle keeps a stale value from looking like a read.
    always_ff @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 8'h00;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `OSMG_ADDR_LINE_OVERLOAD_STATUS: begin
                    // The two flags with zeros around them.
                    rdata_q <= status_view;
                end
                `OSMG_ADDR_MONITOR_RECEIVE_GAIN: begin
                    // The stored code is returned even outside the alternate map.
                    rdata_q <= monitor_rx_gain_code_q;
                end
                `OSMG_ADDR_MONITOR_TRANSMIT_GAIN: begin
                    // Same as the receive code.
                    rdata_q <= monitor_tx_gain_code_q;
                end
                default: begin
                    // Unmapped offsets read as zero.
                    rdata_q <= 8'h00;
                end
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // Outputs come straight from flops; nothing combinational reaches a pin.
    // MONITOR_VALID marks the one cycle in which a fresh mix appears.
    assign REG_RDATA = rdata_q;
    assign CALL_PROGRESS_MONITOR_OUTPUT = monitor_q;
    assign MONITOR_VALID = monitor_valid_q;
    assign SELF_CLEARING_RX_OVERLOAD_FLAG = self_clearing_rx_overload_flag_q;
    assign FEED_OVERLOAD_FLAG = feed_overload_flag_q;

endmodule : osmg_regs

// [osmg_defines.svh]
`ifndef OSMG_DEFINES_SVH
`define OSMG_DEFINES_SVH

// Register offsets on the byte-wide register port.
`define OSMG_ADDR_LINE_OVERLOAD_STATUS 8'h43
`define OSMG_ADDR_MONITOR_RECEIVE_GAIN 8'h44
`define OSMG_ADDR_MONITOR_TRANSMIT_GAIN 8'h45

// Reset values of the three registers.
`define OSMG_RST_LINE_OVERLOAD_STATUS 8'h00
`define OSMG_RST_MONITOR_RECEIVE_GAIN 8'h00
`define OSMG_RST_MONITOR_TRANSMIT_GAIN 8'h00

// Field positions in the overload status register.
`define OSMG_BIT_SELF_CLEARING_RX_OVERLOAD 2
`define OSMG_BIT_FEED_OVERLOAD 0

// Feed overload trip thresholds in mA.
`define OSMG_FEED_TRIP_HIGH_MA 8'ha0
`define OSMG_FEED_TRIP_LOW_MA 8'h3c

// Unity monitor gain code, used while the alternate map is not selected.
`define OSMG_GAIN_UNITY 8'h40
// Right shift that turns a gain product back to sample scale (0x40 is 0 dB).
`define OSMG_GAIN_SHIFT 6

// Timing: clock period, tick period and the derived tick divider count.
`define OSMG_CLK_PERIOD_NS 5
`define OSMG_TICK_NS 1000
`define OSMG_TICK_CYCLES (`OSMG_TICK_NS / `OSMG_CLK_PERIOD_NS)
// Ticks a feed overload must persist before the flag is set.
`define OSMG_FEED_QUAL_TICKS 4'h2

`endif

// [osmg_pkg.sv]
package osmg_pkg;

    typedef logic [7:0] osmg_byte_t;
    typedef logic signed [15:0] osmg_sample_t;
    typedef logic signed [18:0] osmg_scaled_t;

    // Feed overload detector states.
    typedef enum logic [1:0] {
        OSMG_FEED_IDLE = 2'b00,
        OSMG_FEED_QUAL = 2'b01,
        OSMG_FEED_TRIP = 2'b10
    } osmg_feed_state_t;

    // Clamps a wide sum into the monitor sample range.
    function automatic osmg_sample_t osmg_saturate(input logic signed [19:0] value);
        if (value > 20'sh07fff) begin
            osmg_saturate = 16'sh7fff;
        end else if (value < -20'sh08000) begin
            osmg_saturate = -16'sh8000;
        end else begin
            osmg_saturate = value[15:0];
        end
    endfunction : osmg_saturate

endpackage : osmg_pkg

// [osmg_sync.sv]
`timescale 1ns/10ps

module osmg_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);

    logic stage1_q;

    // Two flops; only the second stage is read so metastability stays contained.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1_q <= async_in;
            sync_out <= stage1_q;
        end
    end

endmodule : osmg_sync

// [osmg_gain_scale.sv]
`timescale 1ns/10ps
`include "osmg_defines.svh"

module osmg_gain_scale (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire osmg_pkg::osmg_sample_t sample,
    input wire osmg_pkg::osmg_byte_t gain_code,
    output osmg_pkg::osmg_scaled_t scaled
);
    import osmg_pkg::*;

    logic signed [24:0] product;
    logic signed [24:0] shifted;

    // Linear in amplitude: code 0x40 is unity, so a zero code gives exact silence.
    assign product = sample * $signed({1'b0, gain_code});
    assign shifted = product >>> `OSMG_GAIN_SHIFT;

    // One register stage keeps the multiplier off the summing path.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scaled <= '0;
        end else if (in_valid) begin
            scaled <= shifted[18:0];
        end
    end

endmodule : osmg_gain_scale

// [osmg_regs_chk.sv]
`timescale 1ns/10ps

module osmg_regs_chk (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire osmg_pkg::osmg_byte_t REG_ADDR,
    input wire logic REG_RD,
    input wire osmg_pkg::osmg_byte_t REG_RDATA,
    input wire logic RX_OVERLOAD_LEVEL,
    input wire logic OFFHOOK_MASK,
    input wire osmg_pkg::osmg_byte_t LINE_CURRENT_MA,
    input wire logic CURRENT_LIMIT_SELECT,
    input wire logic OVERLOAD_PROTECT_ENABLE,
    input wire logic OVERLOAD_PROTECT_WR,
    input wire logic SELF_CLEARING_RX_OVERLOAD_FLAG,
    input wire logic FEED_OVERLOAD_FLAG
);
    import osmg_pkg::*;

    // All checks share the single clock, and reset silences them while it is low.
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    // Status reads expose only the two flags; reserved bits must stay zero.
    a_reserved_zero: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h43 |-> REG_RDATA[7:3] == 5'h00 && !REG_RDATA[1])
        else $error("status reserved bits not zero");
    a_status_mirror: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h43 |-> REG_RDATA[2] == $past(SELF_CLEARING_RX_OVERLOAD_FLAG))
        else $error("status bit 2 differs from receive overload flag");
    // The pin passes two sync flops and one register, so the flag trails it by three edges.
    a_ovl_follows: assert property (SELF_CLEARING_RX_OVERLOAD_FLAG == ($past(RX_OVERLOAD_LEVEL, 3) && !$past(OFFHOOK_MASK)))
        else $error("receive overload flag does not follow the level");
    a_mask_only: assert property (OFFHOOK_MASK |=> !SELF_CLEARING_RX_OVERLOAD_FLAG)
        else $error("receive overload flag not masked");
    // The feed flag may only rise when detection was on and the current reached the threshold.
    a_feed_enable: assert property ($rose(FEED_OVERLOAD_FLAG) |-> $past(OVERLOAD_PROTECT_ENABLE))
        else $error("feed flag set while detection disabled");
    a_feed_thresh: assert property ($rose(FEED_OVERLOAD_FLAG) |-> $past(LINE_CURRENT_MA) >= ($past(CURRENT_LIMIT_SELECT) ? 8'h3c : 8'ha0))
        else $error("feed flag set below threshold");
    a_feed_sticky: assert property (FEED_OVERLOAD_FLAG && !OVERLOAD_PROTECT_WR |=> FEED_OVERLOAD_FLAG)
        else $error("feed flag dropped without a clear");
    a_feed_clear: assert property (OVERLOAD_PROTECT_WR && LINE_CURRENT_MA < 8'h3c && $past(LINE_CURRENT_MA) < 8'h3c |=> !FEED_OVERLOAD_FLAG)
        else $error("feed flag not cleared by write");
endmodule : osmg_regs_chk

bind osmg_regs osmg_regs_chk osmg_regs_chk_i (.MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .RX_OVERLOAD_LEVEL(RX_OVERLOAD_LEVEL), .OFFHOOK_MASK(OFFHOOK_MASK),
    .LINE_CURRENT_MA(LINE_CURRENT_MA), .CURRENT_LIMIT_SELECT(CURRENT_LIMIT_SELECT),
    .OVERLOAD_PROTECT_ENABLE(OVERLOAD_PROTECT_ENABLE), .OVERLOAD_PROTECT_WR(OVERLOAD_PROTECT_WR),
    .SELF_CLEARING_RX_OVERLOAD_FLAG(SELF_CLEARING_RX_OVERLOAD_FLAG), .FEED_OVERLOAD_FLAG(FEED_OVERLOAD_FLAG));

// [osmg_regs_test.sv]
`timescale 1ns/10ps

module osmg_regs_test;
    import osmg_pkg::*;
    logic MCLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, RX_OVERLOAD_LEVEL = 1'b0, OFFHOOK_MASK = 1'b0;
    logic CURRENT_LIMIT_SELECT = 1'b0, OVERLOAD_PROTECT_ENABLE = 1'b0, OVERLOAD_PROTECT_WR = 1'b0;
    logic ALT_MAP_SELECT = 1'b0, SAMPLE_VALID = 1'b0, MONITOR_VALID, SELF_CLEARING_RX_OVERLOAD_FLAG, FEED_OVERLOAD_FLAG;
    osmg_byte_t REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, LINE_CURRENT_MA = 8'h00;
    osmg_sample_t RX_SAMPLE = 16'sh0000, TX_SAMPLE = 16'sh0000, CALL_PROGRESS_MONITOR_OUTPUT;
    osmg_byte_t codes[5] = '{8'h7f, 8'h40, 8'h20, 8'h10, 8'h00};
    int mismatches = 0, n_tests = 0, cycles = 0;

    osmg_regs osmg_regs_i (.MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RX_OVERLOAD_LEVEL(RX_OVERLOAD_LEVEL), .OFFHOOK_MASK(OFFHOOK_MASK),
        .LINE_CURRENT_MA(LINE_CURRENT_MA), .CURRENT_LIMIT_SELECT(CURRENT_LIMIT_SELECT),
        .OVERLOAD_PROTECT_ENABLE(OVERLOAD_PROTECT_ENABLE), .OVERLOAD_PROTECT_WR(OVERLOAD_PROTECT_WR),
        .ALT_MAP_SELECT(ALT_MAP_SELECT), .RX_SAMPLE(RX_SAMPLE), .TX_SAMPLE(TX_SAMPLE), .SAMPLE_VALID(SAMPLE_VALID),
        .CALL_PROGRESS_MONITOR_OUTPUT(CALL_PROGRESS_MONITOR_OUTPUT), .MONITOR_VALID(MONITOR_VALID),
        .SELF_CLEARING_RX_OVERLOAD_FLAG(SELF_CLEARING_RX_OVERLOAD_FLAG), .FEED_OVERLOAD_FLAG(FEED_OVERLOAD_FLAG));

    // A 5 ns clock; the watchdog cuts a hang far beyond the few thousand cycles the tests need.
    always #2.5 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    // Compares with case equality, so an unknown never passes.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Bus cycles: one strobe cycle each, read data checked in the single cycle it stands.
    task automatic wr(input osmg_byte_t a, input osmg_byte_t d);
        @(posedge MCLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge MCLK);
        REG_WR <= 1'b0;
    endtask : wr

    task automatic rd(input osmg_byte_t a, input osmg_byte_t exp);
        @(posedge MCLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        #1 chk(REG_RDATA, exp);
    endtask : rd

    // One sample pair in; the mix appears one edge after the edge that takes it.
    task automatic samp(input osmg_sample_t rx, input osmg_sample_t tx, input logic [15:0] exp);
        @(posedge MCLK);
        SAMPLE_VALID <= 1'b1;
        RX_SAMPLE <= rx;
        TX_SAMPLE <= tx;
        @(posedge MCLK);
        SAMPLE_VALID <= 1'b0;
        @(posedge MCLK);
        #1 chk(MONITOR_VALID, 1'b1);
        chk(CALL_PROGRESS_MONITOR_OUTPUT, exp);
    endtask : samp

    // Feed detection qualifies for up to about 401 cycles, so 450 bounds every wait.
    task automatic wait_feed(input logic exp);
        for (int i = 0; i < 450 && !(exp && FEED_OVERLOAD_FLAG === 1'b1); i++) @(posedge MCLK);
        #1 chk(FEED_OVERLOAD_FLAG, exp);
    endtask : wait_feed

    task automatic clr(input logic exp);
        @(posedge MCLK);
        OVERLOAD_PROTECT_WR <= 1'b1;
        @(posedge MCLK);
        OVERLOAD_PROTECT_WR <= 1'b0;
        #1 chk(FEED_OVERLOAD_FLAG, exp);
    endtask : clr

    task automatic results();
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // Main sequence: registers, monitor gains, receive overload, then feed overload.
    initial begin
        repeat (8) @(posedge MCLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge MCLK);
        rd(8'h43, 8'h00);
        rd(8'h44, 8'h00);
        rd(8'h45, 8'h00);
        wr(8'h44, 8'h5a);
        wr(8'h45, 8'ha5);
        wr(8'h43, 8'hff);
        rd(8'h44, 8'h5a);
        rd(8'h45, 8'ha5);
        rd(8'h43, 8'h00);
        rd(8'h50, 8'h00);
        samp(16'sd1000, -16'sd300, 16'sd700);
        @(posedge MCLK);
        ALT_MAP_SELECT <= 1'b1;
        wr(8'h45, 8'h00);
        foreach (codes[i]) begin
            wr(8'h44, codes[i]);
            samp(16'sd640, 16'sd1000, 16'(10 * codes[i]));
        end
        wr(8'h45, 8'h20);
        samp(16'sd640, 16'sd1000, 16'sd500);
        @(posedge MCLK);
        RX_OVERLOAD_LEVEL <= 1'b1;
        repeat (4) @(posedge MCLK);
        #1 chk(SELF_CLEARING_RX_OVERLOAD_FLAG, 1'b1);
        rd(8'h43, 8'h04);
        @(posedge MCLK);
        OFFHOOK_MASK <= 1'b1;
        repeat (2) @(posedge MCLK);
        #1 chk(SELF_CLEARING_RX_OVERLOAD_FLAG, 1'b0);
        @(posedge MCLK);
        OFFHOOK_MASK <= 1'b0;
        RX_OVERLOAD_LEVEL <= 1'b0;
        repeat (5) @(posedge MCLK);
        #1 chk(SELF_CLEARING_RX_OVERLOAD_FLAG, 1'b0);
        @(posedge MCLK);
        OVERLOAD_PROTECT_ENABLE <= 1'b1;
        LINE_CURRENT_MA <= 8'h9f;
        wait_feed(1'b0);
        @(posedge MCLK);
        LINE_CURRENT_MA <= 8'ha0;
        wait_feed(1'b1);
        rd(8'h43, 8'h01);
        clr(1'b1);
        @(posedge MCLK);
        LINE_CURRENT_MA <= 8'h00;
        repeat (50) @(posedge MCLK);
        #1 chk(FEED_OVERLOAD_FLAG, 1'b1);
        clr(1'b0);
        @(posedge MCLK);
        CURRENT_LIMIT_SELECT <= 1'b1;
        LINE_CURRENT_MA <= 8'h3b;
        wait_feed(1'b0);
        @(posedge MCLK);
        LINE_CURRENT_MA <= 8'h3c;
        wait_feed(1'b1);
        @(posedge MCLK);
        LINE_CURRENT_MA <= 8'h00;
        repeat (3) @(posedge MCLK);
        clr(1'b0);
        @(posedge MCLK);
        OVERLOAD_PROTECT_ENABLE <= 1'b0;
        LINE_CURRENT_MA <= 8'hc8;
        wait_feed(1'b0);
        results();
    end
endmodule : osmg_regs_test
